/* design/dbg_mem_cmd.v */
/*
 * debug halt mode executor for memory and control commands.
 * assumes the serial link delivers whole 16-bit words as one-cycle strobes
 * and takes a 17-bit response strobe; a simple memory port answers each access.
 */
`default_nettype none
`include "dbg_cmd_defs.vh"

module dbg_mem_cmd (
  input  wire        i_clock,
  input  wire        i_resetn,
  // command words from the serial link
  input  wire        i_word_valid,
  input  wire [15:0] i_word,
  // response to the serial shifter
  output reg         o_resp_valid,
  output reg  [16:0] o_resp,
  // memory port
  output reg         o_mem_req,
  output reg         o_mem_wr,
  output reg  [31:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  output reg  [1:0]  o_mem_size,
  output reg  [2:0]  o_mem_space,
  input  wire        i_mem_done,
  input  wire        i_mem_err,
  input  wire [31:0] i_mem_rdata,
  // core state
  input  wire [31:0] i_program_counter,
  input  wire [31:0] i_stack_pointer,
  input  wire [2:0]  i_dest_space_code,
  input  wire [2:0]  i_src_space_code,
  input  wire        i_fetch_done,
  input  wire        i_fetch_err,
  output reg         o_pc_load,
  output reg  [31:0] o_pc_value,
  output reg         o_fetch_start,
  output reg         o_exit_halt,
  output reg         o_take_exception,
  output reg  [31:0] o_fault_addr,
  output reg         o_periph_reset
);

  //--------------------------------------------------------------
  // state encoding
  //--------------------------------------------------------------
  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_ADDR  = 9'h002;
  localparam [8:0] S_DATA  = 9'h004;
  localparam [8:0] S_MEM   = 9'h008;
  localparam [8:0] S_RESP  = 9'h010;
  localparam [8:0] S_STACK = 9'h020;
  localparam [8:0] S_FETCH = 9'h040;
  localparam [8:0] S_RST   = 9'h080;
  localparam [8:0] S_RESP2 = 9'h100;

  // sequencer state, command and operand holding
  reg [8:0]  state_ff;
  reg [15:0] cmd_ff;
  reg [31:0] temp_addr_ff;
  reg [31:0] addr_ff;
  reg [31:0] data_ff;
  reg        half_ff;
  reg [9:0]  rst_cnt_ff;
  reg [15:0] lo_word_ff;

  //--------------------------------------------------------------
  // command decode
  //--------------------------------------------------------------
  // checks on the incoming word
  wire [7:0] op_hi     = i_word[15:8];
  wire [1:0] w_size    = i_word[`SIZE_HI:`SIZE_LO];
  wire       size_ok   = (w_size != 2'h3) && (i_word[5:0] == 6'h00);
  wire       is_rd     = (op_hi == `OP_RD_MEM)  && size_ok;
  wire       is_wr     = (op_hi == `OP_WR_MEM)  && size_ok;
  wire       is_rdn    = (op_hi == `OP_RD_NEXT) && size_ok;
  wire       is_wrn    = (op_hi == `OP_WR_NEXT) && size_ok;
  // fields of the command in progress
  wire [1:0] cur_size  = cmd_ff[`SIZE_HI:`SIZE_LO];
  wire       cur_long  = (cur_size == `SIZE_LONG);
  wire       cur_write = (cmd_ff[15:8] == `OP_WR_MEM) || (cmd_ff[15:8] == `OP_WR_NEXT);
  wire       cur_call  = (cmd_ff == `OP_CALL);

  wire [31:0] step_addr;

  //--------------------------------------------------------------
  // address advance
  //--------------------------------------------------------------
  // next block address from the current access address; it is
  // saved after every S_MEM access (not the stack push), error or not, so block commands chain
  addr_step u_step (
    .i_addr (addr_ff),
    .i_size (cur_size),
    .o_next (step_addr)
  );

  //--------------------------------------------------------------
  // sequencer
  //--------------------------------------------------------------
  always @(posedge i_clock or negedge i_resetn) begin
    // constants only in the reset branch
    if (!i_resetn) begin
      state_ff         <= S_IDLE;
      cmd_ff           <= 16'h0000;
      temp_addr_ff     <= 32'h00000000;
      addr_ff          <= 32'h00000000;
      data_ff          <= 32'h00000000;
      half_ff          <= 1'b0;
      rst_cnt_ff       <= 10'h000;
      lo_word_ff       <= 16'h0000;
      o_resp_valid     <= 1'b0;
      o_resp           <= 17'h00000;
      o_mem_req        <= 1'b0;
      o_mem_wr         <= 1'b0;
      o_mem_addr       <= 32'h00000000;
      o_mem_wdata      <= 32'h00000000;
      o_mem_size       <= 2'h0;
      o_mem_space      <= 3'h0;
      o_pc_load        <= 1'b0;
      o_pc_value       <= 32'h00000000;
      o_fetch_start    <= 1'b0;
      o_exit_halt      <= 1'b0;
      o_take_exception <= 1'b0;
      o_fault_addr     <= 32'h00000000;
      o_periph_reset   <= 1'b0;
    end else begin
      // one-cycle strobes default low
      o_resp_valid     <= 1'b0;
      o_pc_load        <= 1'b0;
      o_fetch_start    <= 1'b0;
      o_exit_halt      <= 1'b0;
      o_take_exception <= 1'b0;
      case (state_ff)
        // wait for a command word and dispatch it
        S_IDLE: begin
          half_ff <= 1'b0;
          data_ff <= 32'h00000000;
          if (i_word_valid) begin
            cmd_ff <= i_word;
            if (is_rd || is_wr || (i_word == `OP_CALL)) begin
              state_ff <= S_ADDR;
            end else if (is_rdn) begin
              addr_ff  <= temp_addr_ff;
              state_ff <= S_MEM;
            end else if (is_wrn) begin
              addr_ff  <= temp_addr_ff;
              state_ff <= S_DATA;
            end else if (i_word == `OP_RESUME) begin
              o_pc_value <= i_program_counter;
              state_ff   <= S_FETCH;
              o_fetch_start <= 1'b1;
            end else if (i_word == `OP_PERIPH_RST) begin
              o_periph_reset <= 1'b1;
              rst_cnt_ff     <= `RST_CYCLES - 10'h001;
              state_ff       <= S_RST;
            end else if (i_word == `OP_NULL) begin
              o_resp   <= `RESP_DONE;
              state_ff <= S_RESP;
            end else begin
              o_resp   <= `RESP_UNKNOWN;
              state_ff <= S_RESP;
            end
          end
        end
        S_ADDR: begin
          // long-word address, most significant word first
          if (i_word_valid) begin
            half_ff <= ~half_ff;
            if (!half_ff) begin
              lo_word_ff <= i_word;
            end else begin
              addr_ff <= {lo_word_ff, i_word};
              half_ff <= 1'b0;
              if (cur_call) begin
                state_ff <= S_STACK;
              end else if (cur_write) begin
                state_ff <= S_DATA;
              end else begin
                state_ff <= S_MEM;
              end
            end
          end
        end
        S_DATA: begin
          // byte and word take one word, long takes two
          if (i_word_valid) begin
            data_ff <= {data_ff[15:0], i_word};
            if (cur_long && !half_ff) begin
              half_ff <= 1'b1;
            end else begin
              half_ff  <= 1'b0;
              state_ff <= S_MEM;
            end
          end
        end
        // one access, request held until done
        S_MEM: begin
          if (!o_mem_req) begin
            o_mem_req   <= 1'b1;
            o_mem_wr    <= cur_write;
            o_mem_addr  <= addr_ff;
            o_mem_wdata <= data_ff;
            o_mem_size  <= cur_size;
            o_mem_space <= cur_write ? i_dest_space_code : i_src_space_code;
          end else if (i_mem_done) begin
            o_mem_req    <= 1'b0;
            temp_addr_ff <= step_addr;
            if (i_mem_err) begin
              o_resp <= `RESP_ERR;
            end else if (cur_write) begin
              o_resp <= `RESP_DONE;
            end else if (cur_size == `SIZE_BYTE) begin
              o_resp <= {9'h000, i_mem_rdata[7:0]};
            end else if (cur_size == `SIZE_WORD) begin
              o_resp <= {1'b0, i_mem_rdata[15:0]};
            end else begin
              o_resp  <= {1'b0, i_mem_rdata[31:16]};
              data_ff <= i_mem_rdata;
            end
            state_ff <= (!i_mem_err && !cur_write && cur_long) ? S_RESP2 : S_RESP;
          end
        end
        // long read: two pulses, high word then low word
        S_RESP2: begin
          o_resp_valid <= 1'b1;
          if (!half_ff) begin
            // high word stands in the response for this pulse
            half_ff <= 1'b1;
          end else begin
            half_ff  <= 1'b0;
            o_resp   <= {1'b0, data_ff[15:0]};
            state_ff <= S_IDLE;
          end
        end
        // single response pulse
        S_RESP: begin
          o_resp_valid <= 1'b1;
          state_ff     <= S_IDLE;
        end
        S_STACK: begin
          // push return counter at the stack pointer
          if (!o_mem_req) begin
            o_mem_req   <= 1'b1;
            o_mem_wr    <= 1'b1;
            o_mem_addr  <= i_stack_pointer;
            o_mem_wdata <= i_program_counter;
            o_mem_size  <= `SIZE_LONG;
            o_mem_space <= i_dest_space_code;
          end else if (i_mem_done) begin
            o_mem_req <= 1'b0;
            if (i_mem_err) begin
              o_resp   <= `RESP_ERR;
              state_ff <= S_RESP;
            end else begin
              o_pc_load     <= 1'b1;
              o_pc_value    <= addr_ff;
              o_fetch_start <= 1'b1;
              state_ff      <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          // first prefetch from the new counter
          if (i_fetch_done) begin
            o_exit_halt <= 1'b1;
            if (i_fetch_err) begin
              o_take_exception <= 1'b1;
              o_fault_addr     <= o_pc_value;
            end
            state_ff <= S_IDLE;
          end
        end
        // hold the peripheral reset, then answer
        S_RST: begin
          if (rst_cnt_ff == 10'h000) begin
            o_periph_reset <= 1'b0;
            o_resp         <= `RESP_DONE;
            state_ff       <= S_RESP;
          end else begin
            rst_cnt_ff <= rst_cnt_ff - 10'h001;
          end
        end
        // stray code falls back to idle
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dbg_mem_cmd
`default_nettype wire

/* pkg/dbg_cmd_defs.vh */
/*
 * constants for the debug command executor: opcodes, responses, timing.
 * assumes a 20 MHz core clock and 16-bit command words from the link.
 */
`ifndef DBG_CMD_DEFS_VH
`define DBG_CMD_DEFS_VH

// opcode upper bytes and full opcodes
`define OP_RD_MEM      8'h19
`define OP_WR_MEM      8'h18
`define OP_RD_NEXT     8'h1D
`define OP_WR_NEXT     8'h1C
`define OP_RESUME      16'h0C00
`define OP_CALL        16'h0800
`define OP_PERIPH_RST  16'h0400
`define OP_NULL        16'h0000
// size field position and codes
`define SIZE_HI        7
`define SIZE_LO        6
`define SIZE_BYTE      2'h0
`define SIZE_WORD      2'h1
`define SIZE_LONG      2'h2
// 17-bit responses
`define RESP_DONE      17'h0FFFF
`define RESP_ERR       17'h10001
`define RESP_UNKNOWN   17'h1FFFF
`define RESP_NOTREADY  17'h10000
// peripheral reset length in clocks
`define RST_CYCLES     10'h200

`endif

/* design/addr_step.v */
/*
 * address advance for block transfers: adds 1, 2 or 4 by size code.
 * assumes the size code is already decoded from the command word.
 */
`default_nettype none
`include "dbg_cmd_defs.vh"

module addr_step (
  input  wire [31:0] i_addr,
  input  wire [1:0]  i_size,
  output wire [31:0] o_next
);
  // step by operand size
  assign o_next = i_addr + ((i_size == `SIZE_BYTE) ? 32'h00000001 :
                            (i_size == `SIZE_WORD) ? 32'h00000002 : 32'h00000004);
endmodule // addr_step
`default_nettype wire

/* dv/dbg_mem_checker.sv */
/* port assertions for the debug command executor.
   assumes a bind from the bench top and one clock domain. */
`default_nettype none
`include "dbg_cmd_defs.vh"
// ------------------------------
// checker
// ------------------------------
module dbg_mem_checker (
  input wire        i_clock,
  input wire        i_resetn,
  input wire        o_resp_valid,
  input wire [16:0] o_resp,
  input wire        o_mem_req,
  input wire        o_mem_wr,
  input wire [31:0] o_mem_addr,
  input wire [2:0]  o_mem_space,
  input wire        i_mem_done,
  input wire        i_mem_err,
  input wire [2:0]  i_dest_space_code,
  input wire [2:0]  i_src_space_code,
  input wire        i_fetch_done,
  input wire        i_fetch_err,
  input wire        o_exit_halt,
  input wire        o_take_exception,
  input wire        o_periph_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [10:0] cnt_ff;
  // cycles the reset output has stood high
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) cnt_ff <= 11'h000;
    else cnt_ff <= o_periph_reset ? cnt_ff + 11'h001 : 11'h000;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_done;
    o_resp_valid && o_resp == `RESP_DONE;
  endsequence
  sequence s_err;
    o_resp_valid && o_resp == `RESP_ERR;
  endsequence
  AST_RST_LEN: assert property ($fell(o_periph_reset) |-> cnt_ff == 11'h200)
    else $error("reset output length wrong");
  AST_RST_DONE: assert property ($fell(o_periph_reset) |-> ##[0:2] s_done)
    else $error("no done response after reset output");
  AST_RST_QUIET: assert property (o_periph_reset |-> !o_resp_valid)
    else $error("response while reset output high");
  AST_MEM_ERR: assert property (i_mem_done && i_mem_err |-> ##2 s_err)
    else $error("memory error not answered 10001");
  AST_MEM_HOLD: assert property (o_mem_req && !i_mem_done |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wr))
    else $error("memory request changed before done");
  AST_WR_SPACE: assert property (o_mem_req && o_mem_wr |-> o_mem_space == i_dest_space_code)
    else $error("write space wrong");
  AST_RD_SPACE: assert property (o_mem_req && !o_mem_wr |-> o_mem_space == i_src_space_code)
    else $error("read space wrong");
  AST_FETCH_OK: assert property (i_fetch_done && !i_fetch_err |-> ##[0:2] o_exit_halt)
    else $error("no exit after good fetch");
  AST_FETCH_BAD: assert property (i_fetch_done && i_fetch_err |-> ##[0:2] o_take_exception)
    else $error("no exception after bad fetch");
  AST_RESP_CODES: assert property (o_resp_valid && o_resp[16] |->
    o_resp inside {`RESP_ERR, `RESP_UNKNOWN, `RESP_NOTREADY})
    else $error("bad error response code");
endmodule // dbg_mem_checker
`default_nettype wire

/* dv/mem_model.sv */
/* memory and fetch partner of the executor.
   assumes the executor holds a request until done. */
`default_nettype none
// ------------------------------
// model
// ------------------------------
module mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_fetch_start,
  input  wire logic        i_fetch_bad,
  output var  logic        o_done,
  output var  logic        o_err,
  output var  logic [31:0] o_rdata,
  output var  logic        o_fetch_done,
  output var  logic        o_fetch_err,
  output var  logic [31:0] o_wr_addr,
  output var  logic [31:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff = 4'h0;
  initial {o_done, o_err, o_rdata, o_fetch_done, o_fetch_err} = '0;
  // answer after the delay; released lines toggle
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    o_rdata <= ~o_rdata;
    o_err <= ~o_err;
    o_fetch_done <= i_fetch_start;
    o_fetch_err <= i_fetch_start & i_fetch_bad;
    if (i_req && !o_done) begin
      wait_ff <= (wait_ff == i_delay) ? 4'h0 : wait_ff + 4'h1;
      if (wait_ff == i_delay) begin
        o_done <= 1'b1;
        o_err <= i_addr[31];
        o_rdata <= i_addr ^ 32'h5A5AC3C3;
        if (i_wr) {o_wr_addr, o_wr_data} <= {i_addr, i_wdata};
      end
    end
  end
endmodule // mem_model
`default_nettype wire

/* dv/testbench.sv */
/* self-checking bench for the executor.
   assumes the partner model and checker files. */
`default_nettype none
`include "dbg_cmd_defs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
// ------------------------------
// bench
// ------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0, i_resetn = 0, i_word_valid = 0, fbad = 0;
  logic [15:0] i_word = 16'h0000;
  logic [31:0] pc = 32'h4000, sp = 32'h100;
  logic [3:0] dly = 4'h0;
  logic [16:0] o_resp;
  logic [31:0] maddr, mwd, mrd, pcv, fa, wa, wd;
  logic [1:0] msz;
  logic [2:0] msp;
  logic rv, mreq, mwr, mdone, merr, fdone, ferr, pcl, fst, ex, tk, prst, exs, tks, pls;
  int num_errors = 0, cmp_count = 0, n;
  // command word beside the response it should give
  logic [32:0] rows [4] = '{{16'h0000, `RESP_DONE}, {16'hFFFF, `RESP_UNKNOWN},
    {16'h1DC0, `RESP_UNKNOWN}, {16'h0C01, `RESP_UNKNOWN}};
  dbg_mem_cmd dbg_mem_cmd_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_word_valid(i_word_valid), .i_word(i_word), .o_resp_valid(rv), .o_resp(o_resp),
    .o_mem_req(mreq), .o_mem_wr(mwr), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .o_mem_size(msz), .o_mem_space(msp), .i_mem_done(mdone), .i_mem_err(merr),
    .i_mem_rdata(mrd), .i_program_counter(pc), .i_stack_pointer(sp),
    .i_dest_space_code(3'h5), .i_src_space_code(3'h1), .i_fetch_done(fdone),
    .i_fetch_err(ferr), .o_pc_load(pcl), .o_pc_value(pcv), .o_fetch_start(fst),
    .o_exit_halt(ex), .o_take_exception(tk), .o_fault_addr(fa), .o_periph_reset(prst));
  mem_model mem_model_inst (.i_clock(i_clock), .i_req(mreq), .i_wr(mwr), .i_addr(maddr),
    .i_wdata(mwd), .i_delay(dly), .i_fetch_start(fst), .i_fetch_bad(fbad), .o_done(mdone),
    .o_err(merr), .o_rdata(mrd), .o_fetch_done(fdone), .o_fetch_err(ferr),
    .o_wr_addr(wa), .o_wr_data(wd));
  initial forever #25 i_clock = ~i_clock;
  // one word per pulse, driven on the falling edge
  task send(input logic [15:0] w);
    @(negedge i_clock) {i_word_valid, i_word} = {1'b1, w};
    @(negedge i_clock) i_word_valid = 1'b0;
  endtask
  task send_addr(input logic [15:0] c, input logic [31:0] a);
    send(c); send(a[31:16]); send(a[15:0]);
  endtask
  // wait for a response pulse and compare it
  task get(input logic [16:0] e);
    for (n = 0; n < 1200 && rv !== 1'b1; n++) @(negedge i_clock);
    `CHK({rv, o_resp}, {1'b1, e})
    @(negedge i_clock);
  endtask
  // watch exit and exception for a while
  task watch;
    {exs, tks, pls} = 3'b000;
    repeat (20) @(negedge i_clock) {exs, tks, pls} = {exs | ex, tks | tk, pls | pcl};
  endtask
  task finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clock);
    i_resetn = 1;
    foreach (rows[i]) begin
      send(rows[i][32:17]); get(rows[i][16:0]);
    end
    send_addr(16'h1840, 32'h1000); send(16'h1234); get(`RESP_DONE);
    `CHK(wa, 32'h1000)
    dly = 4'h3;
    send(16'h1C00); send(16'h00AB); get(`RESP_DONE);
    `CHK({wa, wd[7:0]}, {32'h1002, 8'hAB})
    send(16'h0000); get(`RESP_DONE);
    send(16'h1C80); send(16'hCAFE); send(16'hBEEF); get(`RESP_DONE);
    `CHK(msz, `SIZE_LONG)
    `CHK({wa, wd}, {32'h1003, 32'hCAFEBEEF})
    send_addr(16'h1980, 32'h2000); get({1'b0, 16'h5A5A}); get({1'b0, 16'hE3C3});
    send(16'h1D00); get({9'h000, 8'hC7});
    `CHK(msz, `SIZE_BYTE)
    send(16'h1D40); get({1'b0, 16'hE3C6});
    send_addr(16'h1940, 32'h80000000); get(`RESP_ERR);
    send_addr(16'h1800, 32'h80000000); send(16'h0001); get(`RESP_ERR);
    send(16'h1C00); send(16'h0002); get(`RESP_ERR);
    dly = 4'h0;
    send(`OP_PERIPH_RST); n = (prst === 1'b1);
    while (prst === 1'b1) @(negedge i_clock) n += (prst === 1'b1);
    `CHK(n, 512)
    get(`RESP_DONE);
    send(`OP_RESUME); watch; `CHK({exs, tks, pls}, 3'b100)
    fbad = 1; pc = 32'h4001;
    send(`OP_RESUME); watch; `CHK({tks, fa}, {1'b1, 32'h4001})
    fbad = 0; sp = 32'h80000100;
    send_addr(`OP_CALL, 32'h3000); get(`RESP_ERR);
    sp = 32'h100;
    send_addr(`OP_CALL, 32'h3000); watch;
    `CHK({exs, pls, wa, wd, pcv}, {2'b11, sp, pc, 32'h3000})
    // reset in the middle of a peripheral reset pulse
    send(`OP_PERIPH_RST); repeat (5) @(negedge i_clock);
    i_resetn = 0;
    @(negedge i_clock);
    `CHK({prst, rv, pcv}, 34'h0)
    i_resetn = 1;
    send(`OP_NULL); get(`RESP_DONE);
    finish_test;
  end
  // cut a hang short
  initial begin
    #(20000 * 50);
    num_errors++;
    finish_test;
  end
endmodule // testbench
bind dbg_mem_cmd dbg_mem_checker dbg_mem_checker_inst (.i_clock(i_clock),
  .i_resetn(i_resetn), .o_resp_valid(o_resp_valid), .o_resp(o_resp), .o_mem_req(o_mem_req),
  .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_space(o_mem_space),
  .i_mem_done(i_mem_done), .i_mem_err(i_mem_err), .i_dest_space_code(i_dest_space_code),
  .i_src_space_code(i_src_space_code), .i_fetch_done(i_fetch_done),
  .i_fetch_err(i_fetch_err), .o_exit_halt(o_exit_halt),
  .o_take_exception(o_take_exception), .o_periph_reset(o_periph_reset));
`default_nettype wire
